/* File: gwr_gateway.sv */
// Frame routing gateway: rule scan, queue dispatch and loss reporting
`timescale 1ns/1ps
// Behaviour
// [RL1] Forwarding runs by itself; software only clears loss flags.
// [RL2] A frame is never queued back onto its arrival channel.
// [RL3] Only frames matching an enabled rule are forwarded; others are dropped.
// [RL4] One rule reaches at most eight destinations, from one eight-channel group.
// [RL5] Rule table holds 384 rules per channel, 3072 for eight channels.
// [RL6] Each channel's own controller sends queued frames at its own bit timing.
// [RL7] Classical frames become CAN-FD on channels running CAN-FD.
// [RL8] Frames to classical channels are cut to eight bytes.
// [RL9] Four queues per channel; queues 0..2 gateway, queue 3 DMA.
// [RL10] Transmit queue depth is a parameter, sixteen by default.
// [RL11] Rules choose the gateway queue, so sources may share one.
// [RL12] Each source channel has its own four-entry DMA receive FIFO.
// [RL13] The DMA engine drains each receive FIFO right after every frame.
// [RL14] Queues release the lowest identifier first.
// [RL15] A queue overflow sets a sticky flag software can see.
// [RL16] Shared queues may overflow but keep priority order.
// [RL17] A notify rule steers its frame to a separate notification FIFO.
// [RL18] Software may shrink queues to free transmit buffers; here queue depth is fixed at build time by TXQ_DEPTH.
// [RL19] Gateway queues fed by routing, queue 3 by DMA; full drops new.
// [RL20] Any discard sets a sticky loss flag and the loss request output; here only overflows do, frames matching no rule drop unflagged.
module gwr_gateway #(
  parameter int NUM_CH    = gwr_pkg::NUM_CH_DEF,
  parameter int DATA_W    = gwr_pkg::DATA_W_DEF,
  parameter int TXQ_DEPTH = gwr_pkg::TXQ_DEPTH,
  parameter int RXF_DEPTH = gwr_pkg::RXF_DEPTH,
  parameter int FRAME_W   = gwr_pkg::HDR_W + DATA_W,
  parameter int CH_W      = $clog2(NUM_CH),
  parameter int RULE_AW   = $clog2(NUM_CH * gwr_pkg::RULES_PER_CH),
  parameter int LOSS_W    = NUM_CH * gwr_pkg::NUM_Q + NUM_CH + 1
) (
  // Clock and reset
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_srst,
  // Received frames
  input  wire logic                              i_rx_valid,
  input  wire logic [CH_W-1:0]                   i_rx_ch,
  input  wire logic [FRAME_W-1:0]                i_rx_frame,
  output logic                                   o_rx_ready,
  // Rule table and channel setup
  input  wire logic                              i_rule_wr_en,
  input  wire logic [RULE_AW-1:0]                i_rule_wr_addr,
  input  wire logic [gwr_pkg::RULE_W-1:0]        i_rule_wr_data,
  input  wire logic [NUM_CH-1:0]                 i_ch_fd_en,
  // Transmit side per channel
  output logic      [NUM_CH-1:0]                 o_tx_valid,
  output logic      [NUM_CH-1:0][FRAME_W-1:0]    o_tx_frame,
  input  wire logic [NUM_CH-1:0]                 i_tx_ready,
  // DMA receive FIFOs per source channel
  output logic      [NUM_CH-1:0]                 o_dma_rd_valid,
  output logic      [NUM_CH-1:0][FRAME_W-1:0]    o_dma_rd_frame,
  input  wire logic [NUM_CH-1:0]                 i_dma_rd_ready,
  // DMA writes into queue 3
  input  wire logic [NUM_CH-1:0]                 i_dma_wr_valid,
  input  wire logic [NUM_CH-1:0][FRAME_W-1:0]    i_dma_wr_frame,
  output logic      [NUM_CH-1:0]                 o_dma_wr_ready,
  // Notification FIFO
  output logic                                   o_ntf_valid,
  output logic      [FRAME_W-1:0]                o_ntf_frame,
  input  wire logic                              i_ntf_ready,
  // Loss reporting
  output logic      [LOSS_W-1:0]                 o_loss_flags,
  input  wire logic [LOSS_W-1:0]                 i_loss_clr,
  output logic                                   o_loss_req
);
  localparam int IDX_W  = $clog2(gwr_pkg::RULES_PER_CH);
  localparam int NTF_IX = LOSS_W - 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(gwr_pkg::RULES_PER_CH - 1);
  localparam logic [DATA_W-1:0] CLASSIC_MASK =
    {{(DATA_W - gwr_pkg::CLASSIC_BITS){1'b0}}, {gwr_pkg::CLASSIC_BITS{1'b1}}};

  typedef struct packed {
    gwr_pkg::gwr_state_type fsm;
    logic [IDX_W-1:0]       idx;
    logic [CH_W-1:0]        src;
    logic [FRAME_W-1:0]     frame;
    logic [LOSS_W-1:0]      loss;
  } gwr_main_state_type;

  gwr_main_state_type s_reg;
  gwr_main_state_type s_next;

  logic [gwr_pkg::RULE_W-1:0] rule;
  logic [RULE_AW-1:0]         rd_addr;
  logic                       match;
  logic                       go;
  logic                       ntf_push;
  logic                       dma_push;
  logic [1:0]                 qsel;
  logic [NUM_CH-1:0]          dest_hit;
  logic [LOSS_W-1:0]          drops;
  logic [NUM_CH-1:0][gwr_pkg::NUM_Q-1:0]              q_push;
  logic [NUM_CH-1:0][gwr_pkg::NUM_Q-1:0]              q_valid;
  logic [NUM_CH-1:0][gwr_pkg::NUM_Q-1:0]              q_pop;
  logic [NUM_CH-1:0][gwr_pkg::NUM_Q-1:0]              q_full;
  logic [NUM_CH-1:0][gwr_pkg::NUM_Q-1:0][FRAME_W-1:0] q_data;
  logic [NUM_CH-1:0][FRAME_W-1:0]                     conv;

  assign rd_addr = RULE_AW'(int'(s_reg.src) * gwr_pkg::RULES_PER_CH + int'(s_reg.idx)); // [RL5]

  gwr_rule_mem #(
    .W     (gwr_pkg::RULE_W),
    .DEPTH (NUM_CH * gwr_pkg::RULES_PER_CH),
    .AW    (RULE_AW)
  ) u_rules (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (i_rule_wr_en),
    .i_wr_addr (i_rule_wr_addr),
    .i_wr_data (i_rule_wr_data),
    .i_rd_addr (rd_addr),
    .o_rd_data (rule)
  );

  // Identifier match under mask, format bit must agree
  assign match = rule[gwr_pkg::R_EN_BIT] &&
    (rule[gwr_pkg::R_EXT_BIT] == s_reg.frame[gwr_pkg::EXT_BIT]) &&
    ((((rule[gwr_pkg::R_ID_LSB +: gwr_pkg::ID_W]) ^
       (s_reg.frame[gwr_pkg::ID_LSB +: gwr_pkg::ID_W])) &
      rule[gwr_pkg::R_MASK_LSB +: gwr_pkg::ID_W]) == '0); // [RL3]
  assign ntf_push = (s_reg.fsm == gwr_pkg::ST_CHECK) && match && rule[gwr_pkg::R_NTF_BIT]; // [RL17]
  assign go       = (s_reg.fsm == gwr_pkg::ST_CHECK) && match && !rule[gwr_pkg::R_NTF_BIT];
  assign dma_push = go && rule[gwr_pkg::R_DMA_BIT];
  // Queue 3 is never a routing target; an out-of-range choice lands on queue 2
  assign qsel = (rule[gwr_pkg::R_QSEL_LSB +: gwr_pkg::QSEL_W] > gwr_pkg::LAST_GW_Q) ?
                gwr_pkg::LAST_GW_Q : rule[gwr_pkg::R_QSEL_LSB +: gwr_pkg::QSEL_W]; // [RL11]
  assign o_rx_ready = (s_reg.fsm == gwr_pkg::ST_IDLE);

  genvar ch, q;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam int GRP = ch / gwr_pkg::DEST_W;
      localparam int BIT = ch % gwr_pkg::DEST_W;

      assign dest_hit[ch] = go &&
        (rule[gwr_pkg::R_GRP_LSB +: gwr_pkg::GRP_W] == gwr_pkg::GRP_W'(GRP)) && // [RL4]
        rule[gwr_pkg::R_DEST_LSB + BIT] &&
        (s_reg.src != CH_W'(ch)); // [RL2]

      always_comb begin
        conv[ch] = s_reg.frame;
        if (i_ch_fd_en[ch]) begin
          conv[ch][gwr_pkg::FD_BIT] = 1'b1; // [RL7]
        end else begin
          conv[ch][gwr_pkg::FD_BIT] = 1'b0;
          conv[ch][gwr_pkg::HDR_W +: DATA_W] = s_reg.frame[gwr_pkg::HDR_W +: DATA_W] &
                                               CLASSIC_MASK; // [RL8]
          if (s_reg.frame[gwr_pkg::DLC_LSB +: gwr_pkg::DLC_W] > gwr_pkg::CLASSIC_MAX_DLC) begin
            conv[ch][gwr_pkg::DLC_LSB +: gwr_pkg::DLC_W] = gwr_pkg::CLASSIC_MAX_DLC; // [RL8]
          end
        end
      end

      for (q = 0; q < gwr_pkg::NUM_Q; q++) begin : g_q
        if (q == gwr_pkg::DMA_Q) begin : g_dma
          assign q_push[ch][q] = i_dma_wr_valid[ch]; // [RL9] [RL19]
        end else begin : g_gw
          assign q_push[ch][q] = dest_hit[ch] && (qsel == 2'(q)); // [RL9] [RL19]
        end
        gwr_queue #(
          .W          (FRAME_W),
          .DEPTH      (TXQ_DEPTH), // [RL10]
          .PRIO_FIRST (1'b1)
        ) u_txq (
          .i_sys_clk   (i_sys_clk),
          .i_srst      (i_srst),
          .i_push      (q_push[ch][q]),
          .i_push_data ((q == gwr_pkg::DMA_Q) ? i_dma_wr_frame[ch] : conv[ch]),
          .o_full      (q_full[ch][q]),
          .o_drop      (drops[ch * gwr_pkg::NUM_Q + q]), // [RL15]
          .i_pop       (q_pop[ch][q]),
          .o_valid     (q_valid[ch][q]),
          .o_data      (q_data[ch][q])
        );
      end
      assign o_dma_wr_ready[ch] = !q_full[ch][gwr_pkg::DMA_Q];

      // Pick the lowest identifier among the channel's queue heads
      always_comb begin
        int best;
        best = 0;
        for (int k = 1; k < gwr_pkg::NUM_Q; k++) begin
          if (q_valid[ch][k] && (!q_valid[ch][best] ||
              (q_data[ch][k][gwr_pkg::ID_LSB +: gwr_pkg::ID_W] <
               q_data[ch][best][gwr_pkg::ID_LSB +: gwr_pkg::ID_W]))) begin // [RL14]
            best = k;
          end
        end
        o_tx_valid[ch] = |q_valid[ch];
        o_tx_frame[ch] = q_data[ch][best]; // [RL6]
        q_pop[ch]      = '0;
        q_pop[ch][best] = i_tx_ready[ch] && q_valid[ch][best];
      end

      gwr_queue #(
        .W          (FRAME_W),
        .DEPTH      (RXF_DEPTH), // [RL12]
        .PRIO_FIRST (1'b0)
      ) u_rxf (
        .i_sys_clk   (i_sys_clk),
        .i_srst      (i_srst),
        .i_push      (dma_push && (s_reg.src == CH_W'(ch))), // [RL12]
        .i_push_data (s_reg.frame),
        .o_full      (),
        .o_drop      (drops[NUM_CH * gwr_pkg::NUM_Q + ch]),
        .i_pop       (i_dma_rd_ready[ch]), // [RL13]
        .o_valid     (o_dma_rd_valid[ch]),
        .o_data      (o_dma_rd_frame[ch])
      );
    end
  endgenerate

  gwr_queue #(
    .W          (FRAME_W),
    .DEPTH      (gwr_pkg::NTF_DEPTH),
    .PRIO_FIRST (1'b0)
  ) u_ntf (
    .i_sys_clk   (i_sys_clk),
    .i_srst      (i_srst),
    .i_push      (ntf_push), // [RL17]
    .i_push_data (s_reg.frame),
    .o_full      (),
    .o_drop      (drops[NTF_IX]),
    .i_pop       (i_ntf_ready),
    .o_valid     (o_ntf_valid),
    .o_data      (o_ntf_frame)
  );

  // Scan stops at the first matching rule; no match means no forwarding
  always_comb begin
    s_next = s_reg;
    s_next.loss = (s_reg.loss & ~i_loss_clr) | drops; // [RL15] [RL20]
    unique case (s_reg.fsm)
      gwr_pkg::ST_IDLE: begin
        if (i_rx_valid) begin // [RL1]
          s_next.src   = i_rx_ch;
          s_next.frame = i_rx_frame;
          s_next.idx   = '0;
          s_next.fsm   = gwr_pkg::ST_READ;
        end
      end
      gwr_pkg::ST_READ: begin
        s_next.fsm = gwr_pkg::ST_CHECK;
      end
      gwr_pkg::ST_CHECK: begin
        if (match || (s_reg.idx == LAST_IDX)) begin // [RL3] [RL5]
          s_next.fsm = gwr_pkg::ST_IDLE;
        end else begin
          s_next.idx = s_reg.idx + IDX_W'(1);
          s_next.fsm = gwr_pkg::ST_READ;
        end
      end
      default: begin
        s_next.fsm = gwr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_loss_flags = s_reg.loss;
  assign o_loss_req   = |s_reg.loss; // [RL20]

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  sequence seq_take;
    (s_reg.fsm == gwr_pkg::ST_IDLE) && i_rx_valid;
  endsequence
  sequence seq_first_check;
    ##1 (s_reg.fsm == gwr_pkg::ST_READ) ##1 (s_reg.fsm == gwr_pkg::ST_CHECK) && (s_reg.idx == '0);
  endsequence

  chk_scan_start: assert property (seq_take |-> seq_first_check) // [RL1]
    else $error("rule scan did not start after a frame was taken");
  chk_no_echo: assert property (go |-> (q_push[s_reg.src][gwr_pkg::LAST_GW_Q:0] == '0)) // [RL2]
    else $error("frame queued back to its arrival channel");
  chk_miss_no_push: assert property (((s_reg.fsm == gwr_pkg::ST_CHECK) && !match) |-> // [RL3]
                                      (dest_hit == '0) && !ntf_push)
    else $error("unmatched frame was forwarded");
  chk_dest_limit: assert property ($countones(dest_hit) <= gwr_pkg::DEST_W) // [RL4]
    else $error("more than eight destinations");
  chk_scan_bound: assert property ((s_reg.fsm == gwr_pkg::ST_CHECK && s_reg.idx == LAST_IDX) |=> // [RL5]
                                    (s_reg.fsm == gwr_pkg::ST_IDLE))
    else $error("rule scan ran past the last rule");
  chk_classic_dlc: assert property ((q_push[0][0] && !i_ch_fd_en[0]) |-> // [RL8]
      (conv[0][gwr_pkg::DLC_LSB +: gwr_pkg::DLC_W] <= gwr_pkg::CLASSIC_MAX_DLC) &&
      !conv[0][gwr_pkg::FD_BIT])
    else $error("oversize frame queued for a classical channel");
  chk_fd_upconv: assert property ((dest_hit[0] && i_ch_fd_en[0]) |-> conv[0][gwr_pkg::FD_BIT]) // [RL7]
    else $error("frame not sent as CAN-FD on an FD channel");
  chk_notify_only: assert property (ntf_push |-> (dest_hit == '0) && !dma_push) // [RL17]
    else $error("notify frame entered the gateway path");
  chk_loss_sticky: assert property ((drops[0] && !i_loss_clr[0]) ##1 !i_loss_clr[0] |-> // [RL15]
                                     o_loss_flags[0] && o_loss_req)
    else $error("loss flag not held after a drop");
  chk_set_wins: assert property ((|(drops & i_loss_clr)) |=> // [RL20]
                                  ((o_loss_flags & $past(drops)) == $past(drops)))
    else $error("clear beat a simultaneous loss event");
endmodule

/* File: gwr_pkg.sv */
// Shared constants, frame and rule layouts for the frame routing gateway
package gwr_pkg;
  // Frame layout: {payload, dlc, fd, ext, id}
  localparam int ID_W           = 29;
  localparam int ID_LSB         = 0;
  localparam int EXT_BIT        = 29;
  localparam int FD_BIT         = 30;
  localparam int DLC_LSB        = 31;
  localparam int DLC_W          = 4;
  localparam int HDR_W          = 35;
  localparam int DATA_W_DEF     = 512;
  localparam int CLASSIC_BITS   = 64;
  localparam logic [3:0] CLASSIC_MAX_DLC = 4'h8;
  // Rule layout
  localparam int R_ID_LSB       = 0;
  localparam int R_MASK_LSB     = 29;
  localparam int R_EXT_BIT      = 58;
  localparam int R_EN_BIT       = 59;
  localparam int R_DMA_BIT      = 60;
  localparam int R_NTF_BIT      = 61;
  localparam int R_QSEL_LSB     = 62;
  localparam int QSEL_W         = 2;
  localparam int R_DEST_LSB     = 64;
  localparam int DEST_W         = 8;
  localparam int R_GRP_LSB      = 72;
  localparam int GRP_W          = 1;
  localparam int RULE_W         = 73;
  // Resources
  localparam int NUM_CH_DEF     = 8;
  localparam int RULES_PER_CH   = 384;
  localparam int NUM_Q          = 4;
  localparam int DMA_Q          = 3;
  localparam logic [1:0] LAST_GW_Q = 2'h2;
  localparam int TXQ_DEPTH      = 16;
  localparam int RXF_DEPTH      = 4;
  localparam int NTF_DEPTH      = 4;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_CHECK = 2'h2
  } gwr_state_type;
endpackage

/* File: gwr_rule_mem.sv */
// Reception rule table memory with registered read data
`timescale 1ns/1ps
module gwr_rule_mem #(
  parameter int W     = 73,
  parameter int DEPTH = 1536,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic          i_sys_clk,
  // Write port
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [W-1:0]  i_wr_data,
  // Read port
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [W-1:0]  o_rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

/* File: gwr_queue.sv */
// Frame queue, arrival order or highest priority first out
`timescale 1ns/1ps
module gwr_queue #(
  parameter int W          = 547,
  parameter int DEPTH      = 16,
  parameter bit PRIO_FIRST = 1'b1
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  // Fill side
  input  wire logic         i_push,
  input  wire logic [W-1:0] i_push_data,
  output logic              o_full,
  output logic              o_drop,
  // Drain side
  input  wire logic         i_pop,
  output logic              o_valid,
  output logic      [W-1:0] o_data
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int IX_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [CNT_W-1:0]        cnt;
  } gwr_q_state_type;

  gwr_q_state_type s_reg;
  gwr_q_state_type s_next;
  logic [IX_W-1:0] sel;
  logic            do_pop;

  // Slots stay in arrival order, so the first minimum is also the oldest
  always_comb begin
    sel = '0;
    if (PRIO_FIRST) begin
      for (int i = 1; i < DEPTH; i++) begin
        if ((CNT_W'(i) < s_reg.cnt) &&
            (s_reg.slot[i][gwr_pkg::ID_LSB +: gwr_pkg::ID_W] <
             s_reg.slot[sel][gwr_pkg::ID_LSB +: gwr_pkg::ID_W])) begin // [RL14] [RL16]
          sel = IX_W'(i);
        end
      end
    end
  end

  assign o_valid = (s_reg.cnt != '0);
  assign o_data  = s_reg.slot[sel];
  assign do_pop  = i_pop && o_valid;
  assign o_full  = (s_reg.cnt == CNT_W'(DEPTH));
  assign o_drop  = i_push && o_full && !do_pop; // [RL19]

  always_comb begin
    s_next = s_reg;
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        if (IX_W'(i) >= sel) begin
          s_next.slot[i] = s_reg.slot[i + 1];
        end
      end
      s_next.cnt = s_reg.cnt - CNT_W'(1);
    end
    if (i_push && (s_next.cnt < CNT_W'(DEPTH))) begin
      s_next.slot[s_next.cnt[IX_W-1:0]] = i_push_data;
      s_next.cnt = s_next.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  chk_full_no_grow: assert property ( // [RL19]
    (o_full && i_push && !do_pop) |=> (s_reg.cnt == CNT_W'(DEPTH)))
    else $error("full queue changed depth on a dropped push");

  chk_count_step: assert property (
    (i_push && !o_full && !do_pop) |=> (s_reg.cnt == $past(s_reg.cnt) + CNT_W'(1)))
    else $error("queue count did not step on push");

  chk_prio_head: assert property ( // [RL14]
    (PRIO_FIRST && s_reg.cnt > CNT_W'(1)) |->
    (o_data[gwr_pkg::ID_LSB +: gwr_pkg::ID_W] <= s_reg.slot[0][gwr_pkg::ID_LSB +: gwr_pkg::ID_W]))
    else $error("queue head is not the highest priority frame");
endmodule

/* File: gwr_bus_node.sv */
// Far-side bus nodes that take queued frames at their own pace
`timescale 1ns/1ps
module gwr_bus_node #(
  parameter int NUM_CH = 8
) (
  // Clock
  input  wire logic              i_sys_clk,
  // Per-channel stall request from the bench
  input  wire logic [NUM_CH-1:0] i_hold,
  // Pop strobes toward the gateway
  output logic      [NUM_CH-1:0] o_tx_ready
);
  integer seed = 32'h1DA5CA6A;

  initial o_tx_ready = '0;

  // Random gaps stand in for lost arbitration and slow bit rates
  always @(posedge i_sys_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      o_tx_ready[c] <= !i_hold[c] && ($random(seed) % 4 != 0);
    end
  end
endmodule

/* File: can_fd_frame_routing_gateway_test.sv */
// Self-checking bench for the frame routing gateway
`timescale 1ns/1ps
module can_fd_frame_routing_gateway_test;
  localparam int NCH = 8;
  localparam int DW  = 128;
  localparam int FW  = gwr_pkg::HDR_W + DW;
  localparam int TQD = 4;
  localparam int RAW = $clog2(NCH * gwr_pkg::RULES_PER_CH);
  localparam int LW  = NCH * gwr_pkg::NUM_Q + NCH + 1;

  logic                       i_sys_clk      = 1'b0;
  logic                       i_srst         = 1'b1;
  logic                       i_rx_valid     = 1'b0;
  logic [2:0]                 i_rx_ch        = '0;
  logic [FW-1:0]              i_rx_frame     = '0;
  logic                       o_rx_ready;
  logic                       i_rule_wr_en   = 1'b0;
  logic [RAW-1:0]             i_rule_wr_addr = '0;
  logic [gwr_pkg::RULE_W-1:0] i_rule_wr_data = '0;
  logic [NCH-1:0]             i_ch_fd_en     = 8'hAA;
  logic [NCH-1:0]             hold           = '0;
  logic [NCH-1:0]             i_dma_rd_ready = '1;
  logic [NCH-1:0]             i_dma_wr_valid = '0;
  logic [NCH-1:0][FW-1:0]     i_dma_wr_frame = '0;
  logic [LW-1:0]              i_loss_clr     = '0;
  logic                       i_ntf_ready    = 1'b1;
  logic [NCH-1:0]             o_tx_valid;
  logic [NCH-1:0]             i_tx_ready;
  logic [NCH-1:0]             o_dma_rd_valid;
  logic [NCH-1:0]             o_dma_wr_ready;
  logic [NCH-1:0][FW-1:0]     o_tx_frame;
  logic [NCH-1:0][FW-1:0]     o_dma_rd_frame;
  logic                       o_ntf_valid;
  logic [FW-1:0]              o_ntf_frame;
  logic [LW-1:0]              o_loss_flags;
  logic                       o_loss_req;
  logic [FW-1:0]              exp_q[2*NCH+1][$];
  integer                     seed           = 32'h1DA5CA6A;
  int                         fails          = 0;
  int                         n_compared     = 0;

  always #20 i_sys_clk = ~i_sys_clk;

  gwr_gateway #(.NUM_CH(NCH), .DATA_W(DW), .TXQ_DEPTH(TQD), .RXF_DEPTH(4)) dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_rx_valid(i_rx_valid), .i_rx_ch(i_rx_ch),
    .i_rx_frame(i_rx_frame), .o_rx_ready(o_rx_ready), .i_rule_wr_en(i_rule_wr_en),
    .i_rule_wr_addr(i_rule_wr_addr), .i_rule_wr_data(i_rule_wr_data),
    .i_ch_fd_en(i_ch_fd_en), .o_tx_valid(o_tx_valid), .o_tx_frame(o_tx_frame),
    .i_tx_ready(i_tx_ready), .o_dma_rd_valid(o_dma_rd_valid),
    .o_dma_rd_frame(o_dma_rd_frame), .i_dma_rd_ready(i_dma_rd_ready),
    .i_dma_wr_valid(i_dma_wr_valid), .i_dma_wr_frame(i_dma_wr_frame),
    .o_dma_wr_ready(o_dma_wr_ready), .o_ntf_valid(o_ntf_valid), .o_ntf_frame(o_ntf_frame),
    .i_ntf_ready(i_ntf_ready), .o_loss_flags(o_loss_flags), .i_loss_clr(i_loss_clr),
    .o_loss_req(o_loss_req));

  gwr_bus_node #(.NUM_CH(NCH)) node (
    .i_sys_clk(i_sys_clk), .i_hold(hold), .o_tx_ready(i_tx_ready));

  function automatic logic [FW-1:0] mk(input logic [28:0] id, input logic fd,
                                       input logic [3:0] dlc);
    logic [FW-1:0] f;
    f = FW'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed)});
    f[34:0] = {dlc, fd, 1'b0, id};
    return f;
  endfunction

  // Classical targets lose the FD bit, long lengths and upper payload
  function automatic logic [FW-1:0] conv(input logic [FW-1:0] f, input logic fd);
    logic [FW-1:0] g;
    g = f;
    g[30] = fd;
    if (!fd) begin
      if (g[34:31] > 4'h8) g[34:31] = 4'h8;
      g[FW-1:99] = '0;
    end
    return g;
  endfunction

  function automatic logic [72:0] rl(input logic [28:0] id, input logic [28:0] mask,
                                     input logic [3:0] flg, input logic [1:0] q,
                                     input logic [7:0] d);
    return {1'b0, d, q, flg, mask, id};
  endfunction

  task automatic finish_test;
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input int k, input logic [FW-1:0] got);
    n_compared++;
    if (exp_q[k].size() == 0) begin
      fails++;
      $display("ERROR %0t unexpected frame on output %0d", $time, k);
    end else if (exp_q[k].pop_front() !== got) begin
      fails++;
      $display("ERROR %0t wrong frame on output %0d", $time, k);
    end
  endtask

  // Called at a falling edge, where registered status is settled; returns on the next rise
  task automatic chk(input logic [LW:0] got, input logic [LW:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t status %h expected %h", $time, got, exp);
    end
    @(posedge i_sys_clk);
  endtask

  // Rule strobe stays up across back-to-back writes
  task automatic wr_rule(input int a, input logic [72:0] d);
    i_rule_wr_en <= 1'b1;
    i_rule_wr_addr <= RAW'(a);
    i_rule_wr_data <= d;
    @(posedge i_sys_clk);
  endtask

  task automatic send(input logic [2:0] ch, input logic [FW-1:0] f);
    int n;
    n = 0;
    i_rx_ch <= ch;
    i_rx_frame <= f;
    i_rx_valid <= 1'b1;
    // Ready judged mid-cycle, before the edge that takes the frame
    @(negedge i_sys_clk);
    while (o_rx_ready !== 1'b1 && n < 1000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 1000) begin
      fails++;
      $display("ERROR %0t frame intake timed out", $time);
    end
    @(posedge i_sys_clk);
    i_rx_valid <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic fwd0(input logic [FW-1:0] f, input bit keep);
    for (int c = 1; c < NCH; c++) exp_q[c].push_back(conv(f, i_ch_fd_en[c]));
    if (keep) exp_q[NCH].push_back(f);
    send(3'h0, f);
  endtask

  // Results are taken mid-cycle, where pop strobes and frames are settled
  always @(negedge i_sys_clk) begin
    if (!i_srst) begin
      for (int c = 0; c < NCH; c++) begin
        if (o_tx_valid[c] && i_tx_ready[c]) cmp(c, o_tx_frame[c]);
        if (o_dma_rd_valid[c] && i_dma_rd_ready[c]) cmp(NCH + c, o_dma_rd_frame[c]);
      end
      if (o_ntf_valid && i_ntf_ready) cmp(2 * NCH, o_ntf_frame);
    end
  end

  initial begin
    repeat (40000) @(posedge i_sys_clk);
    fails++;
    finish_test();
  end

  initial begin
    logic [FW-1:0] fr[5];
    logic [FW-1:0] f;
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(negedge i_sys_clk);
    chk({o_loss_req, o_loss_flags}, '0);
    @(negedge i_sys_clk);
    chk({o_rx_ready, o_dma_wr_ready, o_tx_valid, o_dma_rd_valid, o_ntf_valid},
        26'h3FE0000);
    // Rule memory has no reset, so every slot is cleared first
    for (int a = 0; a < NCH * 384; a++) wr_rule(a, '0);
    wr_rule(0, rl(29'h100, '1, 4'h6, 2'h0, 8'hFF));
    wr_rule(384, rl(29'h55, '1, 4'hA, 2'h0, 8'h00));
    // Queue choice 3 must land on queue 2
    wr_rule(385, rl(29'h0, '0, 4'h2, 2'h3, 8'h01));
    i_rule_wr_en <= 1'b0;
    @(posedge i_sys_clk);
    fwd0(mk(29'h100, 1'b0, 4'h8), 1'b1);
    fwd0(mk(29'h100, 1'b1, 4'hF), 1'b1);
    send(3'h2, mk(29'h100, 1'b0, 4'h8));
    send(3'h0, mk(29'h101, 1'b0, 4'h8));
    // Extended format must not meet a standard rule
    f = mk(29'h100, 1'b0, 4'h8);
    f[29] = 1'b1;
    send(3'h0, f);
    f = mk(29'h55, 1'b1, 4'h9);
    exp_q[2 * NCH].push_back(f);
    send(3'h1, f);
    // Gateway and DMA frames meet in one channel while its bus is stalled
    hold[0] <= 1'b1;
    fr[0] = mk(29'h300, 1'b0, 4'h8);
    fr[1] = mk(29'h120, 1'b0, 4'h8);
    fr[2] = mk(29'h200, 1'b0, 4'h8);
    fr[3] = mk(29'h050, 1'b0, 4'h8);
    for (int i = 0; i < 3; i++) send(3'h1, fr[i]);
    i_dma_wr_valid[0] <= 1'b1;
    i_dma_wr_frame[0] <= fr[3];
    @(posedge i_sys_clk);
    i_dma_wr_valid[0] <= 1'b0;
    exp_q[0].push_back(fr[3]);
    exp_q[0].push_back(conv(fr[1], 1'b0));
    exp_q[0].push_back(conv(fr[2], 1'b0));
    exp_q[0].push_back(conv(fr[0], 1'b0));
    hold[0] <= 1'b0;
    repeat (40) @(posedge i_sys_clk);
    // One frame more than the queue holds; the newest is the one lost
    hold[0] <= 1'b1;
    for (int i = 0; i <= TQD; i++) begin
      fr[i] = mk(29'(32'h410 - i), 1'b0, 4'h8);
      send(3'h1, fr[i]);
    end
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({o_loss_req, o_loss_flags}, {1'b1, 41'h4});
    for (int i = TQD - 1; i >= 0; i--) exp_q[0].push_back(conv(fr[i], 1'b0));
    hold[0] <= 1'b0;
    i_loss_clr <= 41'h4;
    @(posedge i_sys_clk);
    i_loss_clr <= '0;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({o_loss_req, o_loss_flags}, '0);
    // DMA engine late: the fifth frame is lost while a clear is held, and the loss wins
    i_dma_rd_ready[0] <= 1'b0;
    for (int i = 0; i < 4; i++) fwd0(mk(29'h100, 1'b1, 4'hC), 1'b1);
    i_loss_clr <= 41'h1_0000_0000;
    fwd0(mk(29'h100, 1'b1, 4'hC), 1'b0);
    @(posedge i_sys_clk);
    i_loss_clr <= '0;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({o_loss_req, o_loss_flags}, {1'b1, 41'h1_0000_0000});
    i_dma_rd_ready[0] <= 1'b1;
    i_loss_clr <= 41'h1_0000_0000;
    @(posedge i_sys_clk);
    i_loss_clr <= '0;
    repeat (200) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({o_loss_req, o_loss_flags}, '0);
    for (int k = 0; k <= 2 * NCH; k++) begin
      if (exp_q[k].size() != 0) begin
        fails++;
        $display("ERROR %0t frames missing on output %0d", $time, k);
      end
    end
    finish_test();
  end
endmodule
